//--- hw/nfhc_pkg.sv
// Package for the NAND flash host controller: geometry, commands, timing counts, carrier types.
// Assumes a 50 MHz system clock and a device driven only through its pins.
//
// Contract
// - Command byte latched on write rise, CLE high
// - Address byte latched on write rise, ALE high
// - One shared eight-bit port for everything
// - Five address cycles; column in first two
// - Row bits in cycles three to five
// - Cached read ends with command 3Fh
// - Cached program ends with 80h then 10h
// - After 80h-15h end: poll status, then reset
// - Multi-page cached program ends 81h-10h, else recover
// - Host never drives port while device outputs
// - Read is 00h, address, 30h
// - Program is 80h, address, data, 10h/15h
// - 31h moves next page, holds busy
// - Read busy accepts only status and reset
package nfhc_pkg;
	// ----------------------------------------------------------------
	// Geometry.
	// ----------------------------------------------------------------
	localparam int unsigned PAGE_MAIN_BYTES = 4096;
	localparam int unsigned PAGE_SPARE_BYTES = 256;
	localparam int unsigned PAGE_BYTES = PAGE_MAIN_BYTES + PAGE_SPARE_BYTES;
	localparam int unsigned PAGES_PER_BLOCK = 64;
	localparam int unsigned BLOCK_COUNT = 4096;
	localparam int unsigned COL_W = 13;
	localparam int unsigned ROW_W = 18;
	localparam int unsigned PAGE_SEL_W = 6;
	localparam int unsigned ADDR_CYCLES = 5;
	// ----------------------------------------------------------------
	// Commands.
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_READ_1 = 8'h00;
	localparam logic [7:0] CMD_READ_2 = 8'h30;
	localparam logic [7:0] CMD_READ_CACHE = 8'h31;
	localparam logic [7:0] CMD_READ_LAST = 8'h3f;
	localparam logic [7:0] CMD_PROG_1 = 8'h80;
	localparam logic [7:0] CMD_PROG_MULTI = 8'h81;
	localparam logic [7:0] CMD_PROG_2 = 8'h10;
	localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
	localparam logic [7:0] CMD_ERASE_1 = 8'h60;
	localparam logic [7:0] CMD_ERASE_2 = 8'hd0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_RESET = 8'hff;
	localparam int unsigned STATUS_READY_BIT = 6;
	// ----------------------------------------------------------------
	// Strobe timing, counted in 20 ns cycles.
	// ----------------------------------------------------------------
	localparam int unsigned CLK_NS = 20;
	localparam int unsigned T_PULSE_NS = 25;
	localparam int unsigned T_PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned T_WHR_NS = 60;
	localparam int unsigned T_WHR_CYC = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned T_WB_NS = 100;
	localparam int unsigned T_WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] PULSE_CNT = 4'(T_PULSE_CYC);
	localparam logic [3:0] WHR_CNT = 4'(T_WHR_CYC);
	localparam logic [3:0] WB_CNT = 4'(T_WB_CYC);
	// ----------------------------------------------------------------
	// Operations and carriers.
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_READ = 3'h0, OP_PROG = 3'h1, OP_PROG_CACHE = 3'h2, OP_ERASE = 3'h3,
		OP_STATUS = 3'h4, OP_RESET = 3'h5, OP_READ_CACHE = 3'h6, OP_READ_LAST = 3'h7
	} nfhc_op_t;
	typedef struct packed {
		nfhc_op_t op;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
		logic [12:0] len;
	} nfhc_req_t;
	typedef struct packed {
		logic cle;
		logic ale;
		logic ce_n;
		logic we_n;
		logic wp_n;
	} nfhc_ctl_t;
	typedef enum logic [1:0] {
		CY_CMD = 2'h0, CY_ADDR = 2'h1, CY_WDATA = 2'h2, CY_RDATA = 2'h3
	} nfhc_cy_t;
endpackage : nfhc_pkg

//--- hw/nfhc_strobe.sv
// One-byte strobe engine: drives a write or read strobe pulse on the pins.
// Assumes the caller holds the cycle kind and byte steady while busy.
`timescale 1ns/1ps
`default_nettype none
module nfhc_strobe (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Request.
	input wire logic start,
	input wire nfhc_pkg::nfhc_cy_t kind,
	input wire logic [7:0] wbyte,
	output logic done,
	output logic [7:0] rbyte,
	// Pins.
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic re_n,
	output logic [7:0] io_o,
	output logic io_oe,
	input wire logic [7:0] io_sync
);
	// ----------------------------------------------------------------
	// Phase counter: low half, then high half of the strobe.
	// ----------------------------------------------------------------
	logic [3:0] cnt_q;
	logic [1:0] ph_q; // 0 idle, 1 strobe low, 2 strobe high.
	wire is_rd = (kind == nfhc_pkg::CY_RDATA);
	wire cnt_end = (cnt_q == 4'h1);
	// The strobe rises only after the byte has stood a full pulse width.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ph_q <= 2'h0;
			cnt_q <= 4'h0;
			done <= 1'b0;
			cle <= 1'b0;
			ale <= 1'b0;
			we_n <= 1'b1;
			re_n <= 1'b1;
			io_o <= 8'h00;
			io_oe <= 1'b0;
			rbyte <= 8'h00;
		end else if (clk_en) begin
			done <= 1'b0;
			case (ph_q)
				2'h0: if (start) begin
					ph_q <= 2'h1;
					cnt_q <= nfhc_pkg::PULSE_CNT;
					cle <= (kind == nfhc_pkg::CY_CMD);
					ale <= (kind == nfhc_pkg::CY_ADDR);
					io_o <= wbyte;
					io_oe <= !is_rd;
					we_n <= is_rd;
					re_n <= !is_rd;
				end
				2'h1: if (cnt_end) begin
					ph_q <= 2'h2;
					cnt_q <= nfhc_pkg::PULSE_CNT;
					we_n <= 1'b1; // Device latches on this rise.
					re_n <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
				2'h2: if (cnt_end) begin
					ph_q <= 2'h0;
					cle <= 1'b0;
					ale <= 1'b0;
					io_oe <= 1'b0;
					done <= 1'b1;
					// The port byte needs two clocks through the synchroniser, so it is taken at the end.
					if (is_rd) begin
						rbyte <= io_sync;
					end
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
				default: ph_q <= 2'h0;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	property p_excl;
		@(posedge clk) disable iff (sys_rst) !(cle && ale);
	endproperty
	a_excl: assert property (p_excl) else $error("cle and ale together");
	property p_no_drive_read;
		@(posedge clk) disable iff (sys_rst) !re_n |-> !io_oe;
	endproperty
	a_no_drive_read: assert property (p_no_drive_read) else $error("port driven during read");
	property p_cmd_latch;
		@(posedge clk) disable iff (sys_rst) ($rose(we_n) && clk_en && $past(clk_en)) |-> (cle || ale || io_oe);
	endproperty
	a_cmd_latch: assert property (p_cmd_latch) else $error("write rise with no byte");
endmodule : nfhc_strobe
`default_nettype wire

//--- hw/nfhc_top.sv
// NAND flash host controller: turns one request into command, address, data and wait phases on the pins.
// Assumes a single 50 MHz clock; ready/busy and the I/O port arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module nfhc_top (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Request side.
	input wire logic req_valid,
	input wire nfhc_pkg::nfhc_req_t req,
	input wire logic protect_n,
	output logic req_ready,
	// Write data stream.
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	output logic wr_take,
	// Read data stream.
	output logic rd_valid,
	output logic [7:0] rd_data,
	// Completion.
	output logic op_done,
	output logic [7:0] status_q,
	// Device pins.
	output var nfhc_pkg::nfhc_ctl_t ctl,
	output logic read_strobe_low,
	output logic [7:0] io_o,
	output logic io_oe,
	input wire logic [7:0] io_i,
	input wire logic ready_busy_line
);
	// ----------------------------------------------------------------
	// Synchronisers for the pin inputs.
	// ----------------------------------------------------------------
	logic [7:0] io_s1_q, io_s2_q;
	logic rb_s1_q, rb_s2_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			io_s1_q <= 8'h00;
			io_s2_q <= 8'h00;
			rb_s1_q <= 1'b0;
			rb_s2_q <= 1'b0;
		end else if (clk_en) begin
			io_s1_q <= io_i;
			io_s2_q <= io_s1_q;
			rb_s1_q <= ready_busy_line;
			rb_s2_q <= rb_s1_q;
		end
	end
	wire dev_ready = rb_s2_q;
	// ----------------------------------------------------------------
	// Sequencer states.
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_CMD1 = 4'h1, S_ADDR = 4'h2, S_WDATA = 4'h3, S_CMD2 = 4'h4,
		S_WBSY = 4'h5, S_WAIT = 4'h6, S_RDATA = 4'h7, S_DONE = 4'h8, S_WHR = 4'h9
	} nfhc_st_t;
	nfhc_st_t st_q, st_d;
	nfhc_pkg::nfhc_req_t cur_q;
	logic [2:0] acnt_q;
	logic [12:0] bcnt_q;
	logic [3:0] tw_q;
	logic ce_n_q;
	logic wp_n_q; // Protect pin copy, kept apart so the pin struct has one driver.
	logic go_q;
	// Strobe engine handshake.
	logic sb_done;
	logic [7:0] sb_rbyte;
	logic sb_cle, sb_ale, sb_we_n, sb_re_n, sb_oe;
	logic [7:0] sb_io;
	// ----------------------------------------------------------------
	// Decode of the current operation.
	// ----------------------------------------------------------------
	wire nfhc_pkg::nfhc_op_t op = cur_q.op;
	wire is_prog = (op == nfhc_pkg::OP_PROG) || (op == nfhc_pkg::OP_PROG_CACHE);
	wire has_addr = (op == nfhc_pkg::OP_READ) || is_prog || (op == nfhc_pkg::OP_ERASE);
	wire n_addr_last = (op == nfhc_pkg::OP_ERASE) ? (acnt_q == 3'h2) : (acnt_q == 3'h4);
	wire has_cmd2 = (op == nfhc_pkg::OP_READ) || is_prog || (op == nfhc_pkg::OP_ERASE);
	wire waits = (op != nfhc_pkg::OP_STATUS);
	wire reads = (op == nfhc_pkg::OP_READ) || (op == nfhc_pkg::OP_STATUS)
		|| (op == nfhc_pkg::OP_READ_CACHE) || (op == nfhc_pkg::OP_READ_LAST);
	// First command byte per operation.
	wire [7:0] cmd1 = (op == nfhc_pkg::OP_READ) ? nfhc_pkg::CMD_READ_1 :
		is_prog ? nfhc_pkg::CMD_PROG_1 :
		(op == nfhc_pkg::OP_ERASE) ? nfhc_pkg::CMD_ERASE_1 :
		(op == nfhc_pkg::OP_STATUS) ? nfhc_pkg::CMD_STATUS :
		(op == nfhc_pkg::OP_READ_CACHE) ? nfhc_pkg::CMD_READ_CACHE :
		(op == nfhc_pkg::OP_READ_LAST) ? nfhc_pkg::CMD_READ_LAST : nfhc_pkg::CMD_RESET;
	// Second command byte; the cached program uses 15h, read 30h, erase D0h, otherwise 10h ends it.
	wire [7:0] cmd2 = (op == nfhc_pkg::OP_READ) ? nfhc_pkg::CMD_READ_2 :
		(op == nfhc_pkg::OP_PROG_CACHE) ? nfhc_pkg::CMD_PROG_CACHE :
		(op == nfhc_pkg::OP_ERASE) ? nfhc_pkg::CMD_ERASE_2 : nfhc_pkg::CMD_PROG_2;
	// Address byte from the five-cycle layout; high lines held low. Erase starts at the row.
	wire [2:0] aidx = (op == nfhc_pkg::OP_ERASE) ? (acnt_q + 3'h2) : acnt_q;
	wire [7:0] abyte = (aidx == 3'h0) ? cur_q.col[7:0] :
		(aidx == 3'h1) ? {3'h0, cur_q.col[12:8]} :
		(aidx == 3'h2) ? cur_q.row[7:0] :
		(aidx == 3'h3) ? cur_q.row[15:8] : {6'h00, cur_q.row[17:16]};
	wire nfhc_pkg::nfhc_cy_t kind = (st_q == S_ADDR) ? nfhc_pkg::CY_ADDR :
		(st_q == S_WDATA) ? nfhc_pkg::CY_WDATA :
		(st_q == S_RDATA) ? nfhc_pkg::CY_RDATA : nfhc_pkg::CY_CMD;
	wire [7:0] wbyte = (st_q == S_ADDR) ? abyte : (st_q == S_WDATA) ? wr_data :
		(st_q == S_CMD2) ? cmd2 : cmd1;
	// A byte cycle starts one clock after entering a byte state, or after the last finished.
	wire byte_st = (st_q == S_CMD1) || (st_q == S_ADDR) || (st_q == S_CMD2) || (st_q == S_RDATA)
		|| ((st_q == S_WDATA) && wr_valid);
	wire sb_start = byte_st && go_q;
	wire last_byte = (bcnt_q == 13'h0001);
	// ----------------------------------------------------------------
	// Next-state logic.
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		case (st_q)
			S_IDLE: if (req_valid && dev_ready) st_d = S_CMD1;
			S_CMD1: if (sb_done) st_d = has_addr ? S_ADDR : (waits ? S_WBSY : S_WHR);
			S_ADDR: if (sb_done && n_addr_last) st_d = is_prog ? S_WDATA : (has_cmd2 ? S_CMD2 : S_WBSY);
			S_WDATA: if (sb_done && last_byte) st_d = S_CMD2;
			S_CMD2: if (sb_done) st_d = S_WBSY;
			S_WBSY: if (tw_q == 4'h0) st_d = S_WAIT;
			S_WAIT: if (dev_ready) st_d = reads ? S_RDATA : S_DONE;
			S_WHR: if (tw_q == 4'h0) st_d = S_RDATA;
			S_RDATA: if (sb_done && last_byte) st_d = S_DONE;
			S_DONE: st_d = S_IDLE;
			default: st_d = S_IDLE;
		endcase
	end
	// Request acceptance: program and erase are refused while protect is low.
	wire accept = (st_q == S_IDLE) && req_valid && dev_ready;
	wire prot_drop = accept && !protect_n && ((req.op == nfhc_pkg::OP_PROG) ||
		(req.op == nfhc_pkg::OP_PROG_CACHE) || (req.op == nfhc_pkg::OP_ERASE));
	// ----------------------------------------------------------------
	// State, counters and held request.
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= S_IDLE;
			cur_q <= '0;
			acnt_q <= 3'h0;
			bcnt_q <= 13'h0000;
			tw_q <= 4'h0;
			go_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= prot_drop ? S_DONE : st_d;
			// The start request stays pending until taken, so a late write byte cannot stall the sequencer.
			go_q <= (st_d != st_q) || sb_done || (go_q && !sb_start);
			if (accept) begin
				cur_q <= req;
				bcnt_q <= (req.op == nfhc_pkg::OP_STATUS) ? 13'h0001 : req.len;
			end
			if (st_q != S_ADDR) acnt_q <= 3'h0;
			else if (sb_done) acnt_q <= acnt_q + 3'h1;
			if (sb_done && ((st_q == S_WDATA) || (st_q == S_RDATA))) bcnt_q <= bcnt_q - 13'h0001;
			if (st_d == S_WBSY && st_q != S_WBSY) tw_q <= nfhc_pkg::WB_CNT;
			else if (st_d == S_WHR && st_q != S_WHR) tw_q <= nfhc_pkg::WHR_CNT;
			else if (tw_q != 4'h0) tw_q <= tw_q - 4'h1;
		end
	end
	// ----------------------------------------------------------------
	// Registered outputs.
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ce_n_q <= 1'b1;
			req_ready <= 1'b0;
			op_done <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
			status_q <= 8'h00;
			wr_take <= 1'b0;
			wp_n_q <= 1'b0;
		end else if (clk_en) begin
			// Chip select rises only when idle and ready, giving standby.
			ce_n_q <= (st_d == S_IDLE) && dev_ready;
			req_ready <= (st_d == S_IDLE) && dev_ready;
			op_done <= (st_q == S_DONE);
			rd_valid <= sb_done && (st_q == S_RDATA);
			wr_take <= sb_done && (st_q == S_WDATA);
			wp_n_q <= protect_n;
			if (sb_done && (st_q == S_RDATA)) rd_data <= sb_rbyte;
			if (sb_done && (st_q == S_RDATA) && (op == nfhc_pkg::OP_STATUS)) status_q <= sb_rbyte;
		end
	end
	// The whole pin struct is written by one assignment; every field is a flip-flop.
	assign ctl = '{cle: sb_cle, ale: sb_ale, ce_n: ce_n_q, we_n: sb_we_n, wp_n: wp_n_q};
	assign read_strobe_low = sb_re_n;
	assign io_o = sb_io;
	assign io_oe = sb_oe;
	// ----------------------------------------------------------------
	// Byte strobe engine.
	// ----------------------------------------------------------------
	nfhc_strobe u_strobe (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.start(sb_start),
		.kind(kind),
		.wbyte(wbyte),
		.done(sb_done),
		.rbyte(sb_rbyte),
		.cle(sb_cle),
		.ale(sb_ale),
		.we_n(sb_we_n),
		.re_n(sb_re_n),
		.io_o(sb_io),
		.io_oe(sb_oe),
		.io_sync(io_s2_q)
	);
	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	sequence s_cmd_sent;
		clk_en && (st_q == S_CMD2) && sb_done;
	endsequence
	property p_wait_after_cmd;
		@(posedge clk) disable iff (sys_rst) s_cmd_sent |=> (st_q == S_WBSY);
	endproperty
	a_wait_after_cmd: assert property (p_wait_after_cmd) else $error("no busy wait after confirm");
	property p_ready_gate;
		@(posedge clk) disable iff (sys_rst) (clk_en && st_q == S_IDLE && !dev_ready) |=> (st_q == S_IDLE);
	endproperty
	a_ready_gate: assert property (p_ready_gate) else $error("started while busy");
	property p_five_addr;
		@(posedge clk) disable iff (sys_rst) (st_q == S_ADDR) |-> (acnt_q < 3'h5);
	endproperty
	a_five_addr: assert property (p_five_addr) else $error("too many address cycles");
	property p_addr_hi_low;
		@(posedge clk) disable iff (sys_rst) (st_q == S_ADDR && aidx == 3'h1) |-> (abyte[7:5] == 3'h0);
	endproperty
	a_addr_hi_low: assert property (p_addr_hi_low) else $error("column high lines not low");
	property p_row_hi_low;
		@(posedge clk) disable iff (sys_rst) (st_q == S_ADDR && aidx == 3'h4) |-> (abyte[7:2] == 6'h00);
	endproperty
	a_row_hi_low: assert property (p_row_hi_low) else $error("row high lines not low");
	property p_protect;
		@(posedge clk) disable iff (sys_rst) (clk_en && prot_drop) |=> (st_q == S_DONE);
	endproperty
	a_protect: assert property (p_protect) else $error("protected op started");
endmodule : nfhc_top
`default_nettype wire

//--- sim/nfhc_dev_model.sv
// Behavioural model of the byte-wide flash device, seen only through its pins.
// Assumes one host on the pins; the bench sets how long each busy phase lasts, except the fixed 100 ns after reset and a 10h after 15h, which can run longer.
`timescale 1ns/1ps
`default_nettype none
module nfhc_dev_model (
	// Host pins.
	input wire nfhc_pkg::nfhc_ctl_t ctl,
	input wire logic read_strobe_low,
	input wire logic [7:0] io_o,
	input wire logic io_oe,
	output logic [7:0] io_i,
	output logic ready_busy_line,
	// Bench control.
	input var int busy_ns
);
	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	logic [7:0] mem [bit [30:0]]; // Programmed bytes by row and column; absent means erased.
	logic [7:0] stage [int]; // Page buffer filled by data cycles.
	logic [7:0] cmds [$]; // Commands seen; the bench empties it.
	logic [7:0] adrs [$]; // Address bytes seen; the bench empties it.
	logic [7:0] dout = 8'h00;
	logic [7:0] idle_v = 8'h5a; // A released port shows the inverse of its last value.
	logic drv = 1'b0, busy = 1'b0, stat = 1'b0, cached = 1'b0;
	logic [17:0] row = '0;
	logic [12:0] col = '0;
	int err = 0, fin = 0, a = 0;
	realtime t80 = 0;
	event kick;
	wire [7:0] d = io_i;
	wire standby = ctl.ce_n && !busy; // Busy ignores chip select.
	// Shared port: device first, then host, else the inverted last value.
	assign io_i = drv ? dout : io_oe ? io_o : idle_v;
	// Open drain with a pull-up, low while busy.
	assign ready_busy_line = !busy;
	// ----------------------------------------------------------------
	// Busy timer; a new kick during busy is not seen, so the host must wait.
	// ----------------------------------------------------------------
	always begin
		@(kick);
		busy = 1'b1;
		#(fin);
		busy = 1'b0;
	end
	// Released port lines take the inverse of what was last on them.
	always @(negedge io_oe) idle_v = ~io_o;
	// Output is held until a latch strobe, select or write strobe ends it.
	always @(posedge ctl.cle or posedge ctl.ale or posedge ctl.ce_n or negedge ctl.we_n) if (drv) begin
		drv = 1'b0;
		idle_v = ~dout;
	end
	// Each falling read strobe gives the next byte and steps the column; during status it gives the ready bit and holds the column.
	always @(negedge read_strobe_low) if (!ctl.ce_n) begin
		if (io_oe || (busy && !stat)) err++;
		dout = stat ? 8'(!busy) << nfhc_pkg::STATUS_READY_BIT : mem.exists({row, col}) ? mem[{row, col}] : 8'hff;
		drv = 1'b1;
		if (!stat) col++;
	end
	// Rising write strobe latches a command, an address or a data byte.
	always @(posedge ctl.we_n) if (!ctl.ce_n) begin
		if (ctl.cle && ctl.ale) err++;
		if (busy && !(ctl.cle && (d == 8'h70 || d == 8'hff))) err++;
		if (ctl.cle) begin
			command(d);
		end else if (ctl.ale) begin
			adrs.push_back(d);
			if (adrs.size() == 5) begin
				if (adrs[1][7:5] != 3'h0 || adrs[4][7:2] != 6'h00) err++;
				col = {adrs[1][4:0], adrs[0]};
				row = {adrs[4][1:0], adrs[3], adrs[2]};
			end
		end else begin
			stage[col] = d;
			col++;
		end
	end
	// Command decoder; protect low blocks program and erase.
	task automatic command(input logic [7:0] c);
		bit [30:0] ks [$];
		logic [17:0] er;
		cmds.push_back(c);
		stat = (c == 8'h70);
		fin = busy_ns;
		case (c)
			8'h80, 8'h81: begin
				stage.delete();
				t80 = $realtime;
			end
			8'h30: ->kick;
			8'h31, 8'h3f: begin
				row++;
				col = '0;
				->kick;
			end
			8'h10, 8'h15: if (ctl.wp_n) begin
				foreach (stage[i]) mem[{row, i[12:0]}] = stage[i];
				a = int'($realtime - t80);
				if (c == 8'h10 && cached && a < busy_ns) fin = 2 * busy_ns - a;
				cached = (c == 8'h15);
				->kick;
			end
			8'hd0: if (ctl.wp_n) begin
				er = {adrs[2][1:0], adrs[1], adrs[0]};
				foreach (mem[k]) if (k[30:19] == er[17:6]) ks.push_back(k);
				foreach (ks[i]) mem.delete(ks[i]);
				->kick;
			end
			8'hff: begin
				cached = 1'b0;
				fin = 100;
				->kick;
			end
			default: ;
		endcase
	endtask : command
endmodule : nfhc_dev_model
`default_nettype wire

//--- sim/tb_nfhc_top.sv
// Self-checking bench for the flash host controller against the device model.
// Assumes the design package is compiled first and a 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_nfhc_top;
	// ----------------------------------------------------------------
	// Signals.
	// ----------------------------------------------------------------
	logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, req_valid = 1'b0, protect_n = 1'b1, wr_valid = 1'b0;
	nfhc_pkg::nfhc_req_t req = '0;
	logic [7:0] wr_data = 8'h00;
	logic req_ready, wr_take, rd_valid, op_done, read_strobe_low, io_oe, ready_busy_line, done_seen = 1'b0;
	logic [7:0] rd_data, status_q, io_o, io_i;
	nfhc_pkg::nfhc_ctl_t ctl;
	int busy_ns = 400, fail_count = 0, num_checks = 0;
	logic [7:0] wq [$], rq [$], pat [$], p1 [$]; // Write feed, read capture, expectations.
	logic [17:0] r;
	logic [12:0] c, l;
	initial forever #10 clk = ~clk;
	nfhc_top nfhc_top_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .req_valid(req_valid), .req(req),
		.protect_n(protect_n), .req_ready(req_ready), .wr_valid(wr_valid), .wr_data(wr_data), .wr_take(wr_take),
		.rd_valid(rd_valid), .rd_data(rd_data), .op_done(op_done), .status_q(status_q), .ctl(ctl),
		.read_strobe_low(read_strobe_low), .io_o(io_o), .io_oe(io_oe), .io_i(io_i), .ready_busy_line(ready_busy_line));
	nfhc_dev_model nfhc_dev_model_inst (.ctl(ctl), .read_strobe_low(read_strobe_low), .io_o(io_o), .io_oe(io_oe),
		.io_i(io_i), .ready_busy_line(ready_busy_line), .busy_ns(busy_ns));
	// ----------------------------------------------------------------
	// Streams: feed write bytes, collect read bytes and completions.
	// ----------------------------------------------------------------
	always @(negedge clk) begin
		if (op_done === 1'b1) done_seen = 1'b1;
		if (rd_valid === 1'b1) rq.push_back(rd_data);
		if (wr_take === 1'b1 && wq.size() > 0) void'(wq.pop_front());
		wr_valid = (wq.size() > 0);
		wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
	end
	// ----------------------------------------------------------------
	// Checking and helpers.
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_byte
	// Address byte k of a five-cycle address, worked out from row and column.
	function automatic logic [7:0] exp_adr(input logic [17:0] row, input logic [12:0] col, input int k);
		logic [39:0] a;
		a = {6'h00, row, 3'h0, col};
		return a[8*k +: 8];
	endfunction : exp_adr
	// Random bytes to program, or the erased pattern when nothing is written.
	task automatic fill(input int n, input bit load);
		pat.delete();
		repeat (n) pat.push_back(load ? 8'($urandom) : 8'hff);
		if (load) wq = pat;
	endtask : fill
	task automatic check_cmds(input int n, input logic [7:0] a, input logic [7:0] b);
		chk_byte(8'(nfhc_dev_model_inst.cmds.size()), 8'(n));
		chk_byte(nfhc_dev_model_inst.cmds[0], a);
		if (n > 1) chk_byte(nfhc_dev_model_inst.cmds[1], b);
	endtask : check_cmds
	task automatic check_read(input logic [7:0] e [$]);
		chk_byte(8'(rq.size()), 8'(e.size()));
		foreach (e[i]) chk_byte(rq[i], e[i]);
	endtask : check_read
	// One request: wait until ready, offer it for one edge, wait for completion.
	task automatic run_op(input nfhc_pkg::nfhc_op_t op, input logic [17:0] row, input logic [12:0] col,
		input logic [12:0] len);
		int n;
		n = 0;
		nfhc_dev_model_inst.cmds.delete();
		nfhc_dev_model_inst.adrs.delete();
		rq.delete();
		done_seen = 1'b0;
		while (req_ready !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 5000) begin
			fail_count++;
			stop_test();
		end
		req_valid = 1'b1;
		req = '{op, row, col, len};
		@(negedge clk);
		req_valid = 1'b0;
		while (done_seen !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 20000) begin
			fail_count++;
			stop_test();
		end
	endtask : run_op
	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(9));
		repeat (10) @(posedge clk);
		@(negedge clk);
		chk_byte(8'(ctl.wp_n), 8'h00);
		chk_byte(8'(ctl.ce_n), 8'h01);
		sys_rst = 1'b0;
		// Random pages, the first at the last row and the end of the spare area.
		for (int i = 0; i < 4; i++) begin
			l = (i == 0) ? 13'd16 : 13'(1 + $urandom_range(15));
			r = (i == 0) ? 18'h3ffff : 18'($urandom);
			c = (i == 0) ? 13'(nfhc_pkg::PAGE_BYTES) - l : 13'($urandom_range(4000));
			busy_ns = $urandom_range(3000, 200);
			fill(l, 1'b1);
			run_op(nfhc_pkg::OP_PROG, r, c, l);
			check_cmds(2, 8'h80, 8'h10);
			for (int k = 0; k < 5; k++) chk_byte(nfhc_dev_model_inst.adrs[k], exp_adr(r, c, k));
			run_op(nfhc_pkg::OP_READ, r, c, l);
			check_cmds(2, 8'h00, 8'h30);
			check_read(pat);
		end
		// Cached program then a closing program, status poll and reset.
		r = 18'($urandom) & 18'h3ffc0;
		fill(8, 1'b1);
		p1 = pat;
		run_op(nfhc_pkg::OP_PROG_CACHE, 18'(r + 1), 13'h0000, 13'd8);
		check_cmds(2, 8'h80, 8'h15);
		fill(8, 1'b1);
		run_op(nfhc_pkg::OP_PROG, 18'(r + 2), 13'h0000, 13'd8);
		check_cmds(2, 8'h80, 8'h10);
		run_op(nfhc_pkg::OP_STATUS, r, 13'h0000, 13'd1);
		check_cmds(1, 8'h70, 8'h00);
		chk_byte(status_q, 8'h40);
		run_op(nfhc_pkg::OP_RESET, r, 13'h0000, 13'd0);
		check_cmds(1, 8'hff, 8'h00);
		// Cached read walks to the next pages from column zero.
		run_op(nfhc_pkg::OP_READ, r, 13'h0000, 13'd8);
		run_op(nfhc_pkg::OP_READ_CACHE, r, 13'h0000, 13'd8);
		check_cmds(1, 8'h31, 8'h00);
		check_read(p1);
		run_op(nfhc_pkg::OP_READ_LAST, r, 13'h0000, 13'd8);
		check_cmds(1, 8'h3f, 8'h00);
		check_read(pat);
		// Erase sends only the row bytes and clears the whole block.
		run_op(nfhc_pkg::OP_ERASE, 18'(r + 1), 13'h0000, 13'd0);
		check_cmds(2, 8'h60, 8'hd0);
		for (int k = 0; k < 3; k++) chk_byte(nfhc_dev_model_inst.adrs[k], exp_adr(18'(r + 1), 13'h0, k + 2));
		fill(8, 1'b0);
		run_op(nfhc_pkg::OP_READ, 18'(r + 2), 13'h0000, 13'd8);
		check_read(pat);
		// Protected program is refused; no command reaches the device.
		protect_n = 1'b0;
		run_op(nfhc_pkg::OP_PROG, r, 13'h0000, 13'd4);
		chk_byte(8'(nfhc_dev_model_inst.cmds.size()), 8'h00);
		protect_n = 1'b1;
		chk_byte(8'(nfhc_dev_model_inst.err), 8'h00);
		stop_test();
	end
endmodule : tb_nfhc_top
`default_nettype wire
